// File: design/tod_transfer_opcode_decoder.sv
// tod_transfer_opcode_decoder: decodes data-transfer opcodes from a byte stream
`timescale 1ns/1ps
`default_nettype none

module tod_transfer_opcode_decoder (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic byte_valid,
  output logic byte_ready,
  input wire logic [7:0] byte_data,
  output logic dec_valid,
  input wire logic dec_ready,
  output tod_pkg::tod_result_t dec_result
);
  import tod_pkg::*;

  typedef enum logic [1:0] {
    TOD_ST_FIRST = 2'b00,
    TOD_ST_SECOND = 2'b01,
    TOD_ST_HOLD = 2'b10
  } tod_state_t;

  tod_state_t state_reg;
  tod_op_t cls_op;
  logic [1:0] cls_len;
  logic cls_known;
  tod_result_t result_reg;
  logic take;
  logic first_take;
  logic second_take;

  tod_opcode_class u_class (
    .opcode(byte_data),
    .op(cls_op),
    .length(cls_len),
    .known(cls_known)
  );

  // one instruction in flight; the queue stalls while a result is unconsumed
  assign byte_ready = (state_reg != TOD_ST_HOLD);
  assign take = byte_valid && byte_ready;
  assign dec_valid = (state_reg == TOD_ST_HOLD);
  assign dec_result = result_reg;
  assign first_take = take && state_reg == TOD_ST_FIRST;
  assign second_take = take && state_reg == TOD_ST_SECOND;

  // shared by the field capture and its checks, so both agree on the set
  function automatic logic is_seg_move(input tod_op_t kind);
    return kind == TOD_OP_MOVE_TO_SEG || kind == TOD_OP_MOVE_FROM_SEG;
  endfunction : is_seg_move

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= TOD_ST_FIRST;
    end else begin
      unique case (state_reg)
        TOD_ST_FIRST: begin
          if (take) begin
            state_reg <= (cls_len == LEN_TWO) ? TOD_ST_SECOND : TOD_ST_HOLD;
          end
        end
        TOD_ST_SECOND: begin
          if (take) begin
            state_reg <= TOD_ST_HOLD;
          end
        end
        TOD_ST_HOLD: begin
          if (dec_ready) begin
            state_reg <= TOD_ST_FIRST;
          end
        end
        default: state_reg <= TOD_ST_FIRST;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= '0;
    end else if (take && state_reg == TOD_ST_FIRST) begin
      result_reg <= '0;
      result_reg.op <= cls_op;
      result_reg.length <= cls_len;
      // unknown opcodes are flagged, passed on as one byte so the queue moves
      result_reg.illegal <= !cls_known;
    end else if (take && state_reg == TOD_ST_SECOND) begin
      result_reg.mode <= byte_data[MODE_HI:MODE_LO];
      result_reg.rm_sel <= byte_data[RM_HI:RM_LO];
      if (is_seg_move(result_reg.op)) begin
        result_reg.seg_sel <= byte_data[SEG_HI:SEG_LO];
        // middle field must hold a zero bit
        result_reg.illegal <= byte_data[ZERO_BIT];
      end else begin
        result_reg.reg_sel <= byte_data[REG_HI:REG_LO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_one_byte_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && state_reg == TOD_ST_FIRST && (byte_data == OPC_XLATE || byte_data == OPC_FLAGS_PUSH))
      |=> (dec_valid && dec_result.length == LEN_ONE))
    else $error("one-byte opcode not reported in one cycle");
  chk_xlate_op: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && state_reg == TOD_ST_FIRST && byte_data == OPC_XLATE)
      |=> dec_result.op == TOD_OP_TABLE_TRANSLATE)
    else $error("table translate misdecoded");
  chk_flags_ops: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && state_reg == TOD_ST_FIRST && byte_data == OPC_FLAGS_TO_AH)
      |=> dec_result.op == TOD_OP_FLAGS_TO_ACC_HIGH)
    else $error("flags to accumulator misdecoded");
  chk_flags_pop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && state_reg == TOD_ST_FIRST && byte_data == OPC_FLAGS_POP)
      |=> dec_result.op == TOD_OP_FLAGS_POP)
    else $error("flags pop misdecoded");
  chk_two_byte_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && state_reg == TOD_ST_FIRST && byte_data == OPC_FAR_DSEG)
      |=> !dec_valid && state_reg == TOD_ST_SECOND)
    else $error("two-byte opcode did not wait for addressing byte");
  chk_seg_field: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && state_reg == TOD_ST_SECOND && result_reg.op == TOD_OP_MOVE_TO_SEG)
      |=> dec_valid && dec_result.seg_sel == $past(byte_data[SEG_HI:SEG_LO])
        && dec_result.mode == $past(byte_data[MODE_HI:MODE_LO]))
    else $error("segment move fields wrong");
  chk_seg_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && state_reg == TOD_ST_FIRST && byte_data == OPC_SEG_STORE)
      |=> dec_result.op == TOD_OP_MOVE_FROM_SEG && dec_result.length == LEN_TWO)
    else $error("segment store misdecoded");
  chk_far_reg: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && state_reg == TOD_ST_SECOND && result_reg.op == TOD_OP_LOAD_FAR_DSEG)
      |=> dec_result.reg_sel == $past(byte_data[REG_HI:REG_LO])
        && dec_result.rm_sel == $past(byte_data[RM_HI:RM_LO]))
    else $error("far pointer fields wrong");
  chk_far_eseg: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && state_reg == TOD_ST_FIRST && byte_data == OPC_FAR_ESEG)
      |=> dec_result.op == TOD_OP_LOAD_FAR_ESEG && dec_result.length == LEN_TWO && !dec_valid)
    else $error("extra segment load misdecoded");
  chk_hold_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (dec_valid && !dec_ready) |=> dec_valid && $stable(dec_result))
    else $error("result changed while stalled");

  // opcode classes not reached by the checks above
  chk_flags_push: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (first_take && byte_data == OPC_FLAGS_PUSH)
      |=> dec_result.op == TOD_OP_FLAGS_PUSH && dec_result.length == LEN_ONE)
    else $error("flags push misdecoded");
  chk_acc_to_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (first_take && byte_data == OPC_AH_TO_FLAGS)
      |=> dec_result.op == TOD_OP_ACC_HIGH_TO_FLAGS && dec_result.length == LEN_ONE)
    else $error("accumulator to flags misdecoded");
  chk_seg_load_op: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (first_take && byte_data == OPC_SEG_LOAD)
      |=> dec_result.op == TOD_OP_MOVE_TO_SEG && dec_result.length == LEN_TWO)
    else $error("segment load misdecoded");
  chk_far_dseg_op: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (first_take && byte_data == OPC_FAR_DSEG)
      |=> dec_result.op == TOD_OP_LOAD_FAR_DSEG && dec_result.length == LEN_TWO)
    else $error("data segment load misdecoded");
  chk_unknown_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (first_take && !cls_known)
      |=> dec_valid && dec_result.illegal && dec_result.op == TOD_OP_NONE
        && dec_result.length == LEN_ONE)
    else $error("unknown opcode not flagged as one byte");

  // addressing byte fields, and the two-byte answer presented after the addressing byte
  chk_seg_zero_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (second_take && is_seg_move(result_reg.op))
      |=> dec_result.illegal == $past(byte_data[ZERO_BIT])
        && dec_result.reg_sel == 3'h0)
    else $error("segment move zero bit not judged");
  chk_store_fields: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (second_take && result_reg.op == TOD_OP_MOVE_FROM_SEG)
      |=> dec_result.seg_sel == $past(byte_data[SEG_HI:SEG_LO])
        && dec_result.rm_sel == $past(byte_data[RM_HI:RM_LO]))
    else $error("segment store fields wrong");
  chk_eseg_fields: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (second_take && result_reg.op == TOD_OP_LOAD_FAR_ESEG)
      |=> dec_result.reg_sel == $past(byte_data[REG_HI:REG_LO])
        && dec_result.mode == $past(byte_data[MODE_HI:MODE_LO])
        && dec_result.seg_sel == 2'h0 && !dec_result.illegal)
    else $error("extra segment load fields wrong");
  chk_two_byte_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    second_take
      |=> dec_valid && dec_result.length == LEN_TWO)
    else $error("two-byte result not presented after addressing byte");

  // handshake: one instruction in flight, released on consumption
  chk_release_next: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (dec_valid && dec_ready) |=> !dec_valid && byte_ready)
    else $error("result not released after consumption");
  chk_refuse_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dec_valid |-> !byte_ready && !take)
    else $error("byte accepted while a result waits");
  chk_answer_source: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(dec_valid) |-> $past(take))
    else $error("result appeared without a byte taken");

  // main scenarios seen at the consumer side

  cov_one_byte: cover property (@(posedge clk_sys) disable iff (!rst_n)
    dec_valid && dec_ready && dec_result.length == LEN_ONE);
  cov_two_byte: cover property (@(posedge clk_sys) disable iff (!rst_n)
    dec_valid && dec_ready && dec_result.length == LEN_TWO && !dec_result.illegal);
  cov_stall: cover property (@(posedge clk_sys) disable iff (!rst_n)
    dec_valid && !dec_ready ##1 dec_valid && dec_ready);
  cov_illegal: cover property (@(posedge clk_sys) disable iff (!rst_n)
    dec_valid && dec_result.illegal);
  cov_seg_illegal: cover property (@(posedge clk_sys) disable iff (!rst_n)
    dec_valid && dec_result.illegal && is_seg_move(dec_result.op));

endmodule : tod_transfer_opcode_decoder

`default_nettype wire

// File: design/tod_pkg.sv
// tod_pkg: opcode constants, operation enum and decode result carrier
package tod_pkg;

  localparam logic [7:0] OPC_SEG_LOAD = 8'h8E;
  localparam logic [7:0] OPC_SEG_STORE = 8'h8C;
  localparam logic [7:0] OPC_XLATE = 8'hD7;
  localparam logic [7:0] OPC_FAR_DSEG = 8'hC5;
  localparam logic [7:0] OPC_FAR_ESEG = 8'hC4;
  localparam logic [7:0] OPC_FLAGS_TO_AH = 8'h9F;
  localparam logic [7:0] OPC_FLAGS_PUSH = 8'h9C;
  localparam logic [7:0] OPC_AH_TO_FLAGS = 8'h9E;
  localparam logic [7:0] OPC_FLAGS_POP = 8'h9D;

  // addressing byte field positions
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int REG_HI = 5;
  localparam int REG_LO = 3;
  localparam int ZERO_BIT = 5;
  localparam int SEG_HI = 4;
  localparam int SEG_LO = 3;
  localparam int RM_HI = 2;
  localparam int RM_LO = 0;

  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;

  typedef enum logic [3:0] {
    TOD_OP_NONE = 4'h0,
    TOD_OP_MOVE_TO_SEG = 4'h1,
    TOD_OP_MOVE_FROM_SEG = 4'h2,
    TOD_OP_TABLE_TRANSLATE = 4'h3,
    TOD_OP_LOAD_FAR_DSEG = 4'h4,
    TOD_OP_LOAD_FAR_ESEG = 4'h5,
    TOD_OP_FLAGS_TO_ACC_HIGH = 4'h6,
    TOD_OP_FLAGS_PUSH = 4'h7,
    TOD_OP_ACC_HIGH_TO_FLAGS = 4'h8,
    TOD_OP_FLAGS_POP = 4'h9
  } tod_op_t;

  typedef struct packed {
    tod_op_t op;
    logic [1:0] length;
    logic [1:0] mode;
    logic [2:0] reg_sel;
    logic [1:0] seg_sel;
    logic [2:0] rm_sel;
    logic illegal;
  } tod_result_t;

endpackage : tod_pkg

// File: design/tod_opcode_class.sv
// tod_opcode_class: combinational classification of a first opcode byte
`timescale 1ns/1ps
`default_nettype none

module tod_opcode_class (
  input wire logic [7:0] opcode,
  output tod_pkg::tod_op_t op,
  output logic [1:0] length,
  output logic known
);
  import tod_pkg::*;

  always_comb begin
    op = TOD_OP_NONE;
    length = LEN_ONE;
    known = 1'b1;
    unique case (opcode)
      OPC_SEG_LOAD: begin
        op = TOD_OP_MOVE_TO_SEG;
        length = LEN_TWO;
      end
      OPC_SEG_STORE: begin
        op = TOD_OP_MOVE_FROM_SEG;
        length = LEN_TWO;
      end
      OPC_XLATE: op = TOD_OP_TABLE_TRANSLATE;
      OPC_FAR_DSEG: begin
        op = TOD_OP_LOAD_FAR_DSEG;
        length = LEN_TWO;
      end
      OPC_FAR_ESEG: begin
        op = TOD_OP_LOAD_FAR_ESEG;
        length = LEN_TWO;
      end
      OPC_FLAGS_TO_AH: op = TOD_OP_FLAGS_TO_ACC_HIGH;
      OPC_FLAGS_PUSH: op = TOD_OP_FLAGS_PUSH;
      OPC_AH_TO_FLAGS: op = TOD_OP_ACC_HIGH_TO_FLAGS;
      OPC_FLAGS_POP: op = TOD_OP_FLAGS_POP;
      default: known = 1'b0;
    endcase
  end

endmodule : tod_opcode_class

`default_nettype wire

// File: dv/tod_byte_source.sv
// tod_byte_source: prefetch queue model offering instruction bytes
`timescale 1ns/1ps
`default_nettype none
module tod_byte_source (
  input wire logic clk_sys,
  input wire logic byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic [7:0] q[$];
  logic taken = 1'b0;
  int stall = 0;
  int hold = 0;
  initial byte_valid = 1'b0;
  initial byte_data = 8'h5A;
  always @(posedge clk_sys) taken <= byte_valid & byte_ready;
  // offer held until taken; idle data toggles so nothing stale can pass
  always @(negedge clk_sys) begin
    if (taken) begin
      void'(q.pop_front());
      hold = stall;
    end
    if (!byte_valid || taken) begin
      if (q.size() > 0 && hold == 0) begin
        byte_valid = 1'b1;
        byte_data = q[0];
      end else begin
        if (hold > 0) hold--;
        byte_valid = 1'b0;
        byte_data = ~byte_data;
      end
    end
  end
endmodule : tod_byte_source
`default_nettype wire

// File: dv/test_tod_transfer_opcode_decoder.sv
// test_tod_transfer_opcode_decoder: self-checking bench for the opcode decoder
`timescale 1ns/1ps
`default_nettype none
module test_tod_transfer_opcode_decoder;
  import tod_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic dec_ready = 1'b0;
  logic byte_valid, byte_ready, dec_valid;
  logic [7:0] byte_data;
  tod_result_t dec_result;
  int failures = 0;
  int n_checks = 0;
  initial forever #4 clk_sys = ~clk_sys;
  tod_byte_source src (.clk_sys(clk_sys), .byte_ready(byte_ready), .byte_valid(byte_valid),
    .byte_data(byte_data));
  tod_transfer_opcode_decoder tod_transfer_opcode_decoder_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .byte_valid(byte_valid), .byte_ready(byte_ready), .byte_data(byte_data),
    .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_result(dec_result));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_res(input string what, input tod_result_t exp, input tod_result_t got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_res
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  // full=0 judges only the illegal flag, other fields being left open
  task automatic decode(input logic [7:0] b0, b1, input tod_result_t exp, input int park,
      input logic full);
    int n;
    n = 0;
    src.q.push_back(b0);
    if (exp.length == LEN_TWO) src.q.push_back(b1);
    while (dec_valid !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    chk_bit("dec_valid", 1'b1, dec_valid);
    if (full) chk_res("dec_result", exp, dec_result);
    else chk_bit("illegal", exp.illegal, dec_result.illegal);
    repeat (park) begin
      @(negedge clk_sys);
      chk_bit("byte_ready", 1'b0, byte_ready);
      if (full) chk_res("held result", exp, dec_result);
      else chk_bit("held illegal", exp.illegal, dec_result.illegal);
    end
    dec_ready = 1'b1;
    @(negedge clk_sys);
    dec_ready = 1'b0;
    chk_bit("dec_valid", 1'b0, dec_valid);
    chk_bit("byte_ready", 1'b1, byte_ready);
  endtask : decode
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_one_byte();
    logic [7:0] code[5] = '{OPC_XLATE, OPC_FLAGS_TO_AH, OPC_FLAGS_PUSH, OPC_AH_TO_FLAGS,
      OPC_FLAGS_POP};
    tod_op_t op[5] = '{TOD_OP_TABLE_TRANSLATE, TOD_OP_FLAGS_TO_ACC_HIGH, TOD_OP_FLAGS_PUSH,
      TOD_OP_ACC_HIGH_TO_FLAGS, TOD_OP_FLAGS_POP};
    for (int i = 0; i < 5; i++) begin
      decode(code[i], 8'h00, '{op[i], LEN_ONE, 2'h0, 3'h0, 2'h0, 3'h0, 1'b0}, 0, 1'b1);
    end
    $display("test one_byte done");
  endtask : t_one_byte
  task automatic t_segment();
    decode(OPC_SEG_LOAD, 8'hDA, '{TOD_OP_MOVE_TO_SEG, LEN_TWO, 2'h3, 3'h0, 2'h3, 3'h2, 1'b0},
      2, 1'b1);
    decode(OPC_SEG_STORE, 8'h0F, '{TOD_OP_MOVE_FROM_SEG, LEN_TWO, 2'h0, 3'h0, 2'h1, 3'h7, 1'b0},
      0, 1'b1);
    decode(OPC_SEG_LOAD, 8'h20, '{TOD_OP_MOVE_TO_SEG, LEN_TWO, 2'h0, 3'h0, 2'h0, 3'h0, 1'b1},
      0, 1'b0);
    $display("test segment done");
  endtask : t_segment
  task automatic t_far();
    src.stall = 2;
    decode(OPC_FAR_DSEG, 8'h5E, '{TOD_OP_LOAD_FAR_DSEG, LEN_TWO, 2'h1, 3'h3, 2'h0, 3'h6, 1'b0},
      1, 1'b1);
    decode(OPC_FAR_ESEG, 8'hA1, '{TOD_OP_LOAD_FAR_ESEG, LEN_TWO, 2'h2, 3'h4, 2'h0, 3'h1, 1'b0},
      0, 1'b1);
    src.stall = 0;
    decode(8'h8D, 8'h00, '{TOD_OP_NONE, LEN_ONE, 2'h0, 3'h0, 2'h0, 3'h0, 1'b1}, 3, 1'b1);
    $display("test far_and_unknown done");
  endtask : t_far
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #(8 * 5000);
    failures++;
    give_verdict();
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    chk_bit("reset byte_ready", 1'b1, byte_ready);
    chk_bit("reset dec_valid", 1'b0, dec_valid);
    rst_n = 1'b1;
    t_one_byte();
    t_segment();
    t_far();
    give_verdict();
  end
endmodule : test_tod_transfer_opcode_decoder
`default_nettype wire
